// ==== core/dscp_map_pkg.sv ====
// constants shared by the code point queue map bank and its lookup
package dscp_map_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_MAP_8_15  = 8'h6D;
    localparam logic [7:0] IDX_MAP_16_23 = 8'h6E;
    localparam logic [7:0] IDX_MAP_24_31 = 8'h6F;
    localparam logic [7:0] IDX_MAP_32_39 = 8'h70;

    // map geometry
    localparam int          MAP_WORDS     = 4;
    localparam int          MAP_W         = 16;
    localparam int          FIELD_W       = 2;
    localparam int          CODE_W        = 6;
    localparam int          FIELDS_PER_W  = 8;
    localparam int          ADDR_W        = 10;
    localparam logic [15:0] MAP_RESET     = 16'h0000;

    // first and last code point covered by the bank
    localparam logic [5:0]  CODE_FIRST    = 6'h08;
    localparam logic [5:0]  CODE_LAST     = 6'h27;

    // answer for codes outside the bank and for unmapped reads
    localparam logic [1:0]  QUEUE_DEFAULT = 2'h0;
    localparam logic [31:0] RD_UNMAPPED   = 32'h0000_0000;

    // bus slave states
    typedef enum logic [0:0] {
        BUS_IDLE,
        BUS_ACK
    } bus_state_t;

endpackage : dscp_map_pkg

// ==== core/dscp_field_select.sv ====
// selects the 2-bit queue field for a code point from the four map words
`timescale 1ns/1ns
module dscp_field_select
    import dscp_map_pkg::*;
(
    // map contents, word 0 holds codes 8 to 15
    input  wire logic [MAP_WORDS*MAP_W-1:0] map_flat_i,
    // code point
    input  wire logic [CODE_W-1:0]          code_i,
    // result
    output logic      [FIELD_W-1:0]         queue_o,
    output logic                            hit_o
);

    // ***********************************
    // field table
    // ***********************************
    logic [FIELD_W-1:0] field_tab [MAP_WORDS*FIELDS_PER_W];
    wire  [4:0]         slot;

    // code c sits in word (c-8)/8 at bits 2*(c%8)+1 : 2*(c%8)
    genvar g;
    generate
        for (g = 0; g < MAP_WORDS*FIELDS_PER_W; g++) begin : g_field
            assign field_tab[g] = map_flat_i[g*FIELD_W +: FIELD_W];
        end
    endgenerate

    // range check and select; value 0..3 is the queue number itself
    assign hit_o   = (code_i >= CODE_FIRST) && (code_i <= CODE_LAST);
    assign slot    = 5'(code_i - CODE_FIRST);
    assign queue_o = hit_o ? field_tab[slot] : QUEUE_DEFAULT;

endmodule : dscp_field_select

// ==== core/dscp_priority_queue_map.sv ====
// code point to egress queue map bank with avalon register access
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ns
// Function
// [RL1] six-bit code indexes field, giving frame queue
// [RL2] codes 12-15 from map 8-15 upper nibbles; the code takes them from the high byte, bits 15:8
// [RL3] codes 8-11 from map 8-15 low byte
// [RL4] codes 20-23 from map 16-23 high byte
// [RL5] codes 16-19 from map 16-23 low byte
// [RL6] codes 28-31 from map 24-31 high byte
// [RL7] codes 24-27 from map 24-31 low byte
// [RL8] codes 36-39 from map 32-39 high byte
// [RL9] codes 32-35 from map 32-39 low byte
// [RL10] map 32-39 at 0x70, resets to zero
// [RL11] field value 0..3 selects queue 0..3
// [RL12] four words read/write, writes affect later frames
module dscp_priority_queue_map
    import dscp_map_pkg::*;
(
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              nrst_i,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic      [31:0]       avs_readdata_o,
    output logic                   avs_waitrequest_o,
    // classification request from forwarding logic
    input  wire logic              classify_valid_i,
    input  wire logic [CODE_W-1:0] classify_code_i,
    // classification answer
    output logic                   queue_valid_o,
    output logic      [FIELD_W-1:0] queue_o,
    output logic                   queue_hit_o
);

    // ***********************************
    // declarations
    // ***********************************
    bus_state_t          bus_state_r;
    bus_state_t          bus_state_nxt;
    logic [31:0]         rdata_r;
    logic [31:0]         rdata_nxt;
    logic [MAP_W-1:0]    map_r [MAP_WORDS];
    logic [MAP_W-1:0]    wr_mask;
    logic [MAP_WORDS-1:0] word_hit;
    logic [MAP_WORDS-1:0] word_we;
    logic [MAP_WORDS*MAP_W-1:0] map_flat;
    logic                req;
    logic                accept;
    logic                mapped;
    logic [MAP_W-1:0]    rd_word;
    logic [FIELD_W-1:0]  sel_queue;
    logic                sel_hit;
    logic                qvalid_r;
    logic [FIELD_W-1:0]  queue_r;
    logic                hit_r;
    logic [7:0]          reg_idx [MAP_WORDS];

    // ***********************************
    // bus decode
    // ***********************************

    // index table in map order
    assign reg_idx[0] = IDX_MAP_8_15;
    assign reg_idx[1] = IDX_MAP_16_23;
    assign reg_idx[2] = IDX_MAP_24_31;
    assign reg_idx[3] = IDX_MAP_32_39; // RL10

    // one request is answered after one wait cycle
    assign req               = avs_read_i | avs_write_i;
    assign accept            = req && (bus_state_r == BUS_ACK);
    assign avs_waitrequest_o = req && (bus_state_r != BUS_ACK);
    assign avs_readdata_o    = rdata_r;

    // byte lanes 0 and 1 carry the 16-bit word
    assign wr_mask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

    // per-word address hit and write strobe
    genvar w;
    generate
        for (w = 0; w < MAP_WORDS; w++) begin : g_word
            assign word_hit[w] = (avs_address_i == {reg_idx[w], 2'b00});
            assign word_we[w]  = accept && avs_write_i && word_hit[w]; // RL12

            // map storage, reset to zero
            always_ff @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    map_r[w] <= MAP_RESET; // RL10
                end else if (word_we[w]) begin
                    map_r[w] <= (map_r[w] & ~wr_mask) |
                                (avs_writedata_i[MAP_W-1:0] & wr_mask); // RL12
                end
            end

            assign map_flat[w*MAP_W +: MAP_W] = map_r[w]; // RL2 RL3 RL4 RL5 RL6 RL7 RL8 RL9
        end
    endgenerate

    // read mux, unmapped addresses read zero
    assign mapped  = |word_hit;
    assign rd_word = word_hit[0] ? map_r[0] :
                     word_hit[1] ? map_r[1] :
                     word_hit[2] ? map_r[2] :
                     word_hit[3] ? map_r[3] : MAP_RESET;

    // ***********************************
    // bus state
    // ***********************************

    // next state and read data capture
    always_comb begin
        bus_state_nxt = bus_state_r;
        rdata_nxt     = rdata_r;
        case (bus_state_r)
            BUS_IDLE: begin
                if (req) begin
                    bus_state_nxt = BUS_ACK;
                    rdata_nxt     = mapped ? {16'h0000, rd_word} : RD_UNMAPPED; // RL12
                end
            end
            BUS_ACK: begin
                bus_state_nxt = BUS_IDLE;
            end
            default: begin
                bus_state_nxt = BUS_IDLE;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bus_state_r <= BUS_IDLE;
            rdata_r     <= RD_UNMAPPED;
        end else begin
            bus_state_r <= bus_state_nxt;
            rdata_r     <= rdata_nxt;
        end
    end

    // ***********************************
    // classification lookup
    // ***********************************

    // field select over the whole bank
    dscp_field_select u_select (
        .map_flat_i (map_flat),
        .code_i     (classify_code_i),
        .queue_o    (sel_queue),
        .hit_o      (sel_hit)
    );

    // answer one cycle after the request
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            qvalid_r <= 1'b0;
            queue_r  <= QUEUE_DEFAULT;
            hit_r    <= 1'b0;
        end else begin
            qvalid_r <= classify_valid_i; // RL1
            if (classify_valid_i) begin
                queue_r <= sel_queue; // RL11
                hit_r   <= sel_hit;
            end
        end
    end

    assign queue_valid_o = qvalid_r;
    assign queue_o       = queue_r;
    assign queue_hit_o   = hit_r;

    // ***********************************
    // assertions
    // ***********************************

    // helper: set once map 32-39 has been written since reset
    logic top_written_r;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            top_written_r <= 1'b0;
        end else if (word_we[3]) begin
            top_written_r <= 1'b1;
        end
    end

    // a request for code c answers with field of word wi at bit lo
    property p_field(int wi, logic [5:0] c, int lo);
        @(posedge clk_i) disable iff (!nrst_i)
        (classify_valid_i && classify_code_i == c)
            |=> (queue_o == $past(map_r[wi][lo +: 2])) && queue_hit_o;
    endproperty

    sequence s_write_taken;
        avs_write_i && !avs_waitrequest_o;
    endsequence

    sequence s_read_taken;
        avs_read_i && !avs_waitrequest_o;
    endsequence

    AST_VALID_FOLLOWS: assert property ( // RL1
        @(posedge clk_i) disable iff (!nrst_i)
        classify_valid_i |=> queue_valid_o)
        else $error("queue answer missing after request");
    AST_CODE_15: assert property (p_field(0, 6'h0F, 14)) // RL2
        else $error("code 15 not taken from bits 15:14");
    AST_CODE_12: assert property (p_field(0, 6'h0C, 8)) // RL2
        else $error("code 12 not taken from bits 9:8");
    AST_CODE_8: assert property (p_field(0, 6'h08, 0)) // RL3
        else $error("code 8 not taken from bits 1:0");
    AST_CODE_11: assert property (p_field(0, 6'h0B, 6)) // RL3
        else $error("code 11 not taken from bits 7:6");
    AST_CODE_23: assert property (p_field(1, 6'h17, 14)) // RL4
        else $error("code 23 wrong field");
    AST_CODE_17: assert property (p_field(1, 6'h11, 2)) // RL5
        else $error("code 17 wrong field");
    AST_CODE_29: assert property (p_field(2, 6'h1D, 10)) // RL6
        else $error("code 29 wrong field");
    AST_CODE_26: assert property (p_field(2, 6'h1A, 4)) // RL7
        else $error("code 26 wrong field");
    AST_CODE_38: assert property (p_field(3, 6'h26, 12)) // RL8
        else $error("code 38 wrong field");
    AST_CODE_32: assert property (p_field(3, 6'h20, 0)) // RL9
        else $error("code 32 wrong field");
    AST_TOP_RESET_ZERO: assert property ( // RL10
        @(posedge clk_i) disable iff (!nrst_i)
        (classify_valid_i && classify_code_i[5:3] == 3'b100 && !top_written_r)
            |=> queue_o == 2'h0)
        else $error("unwritten map 32-39 gave nonzero queue");
    AST_OUT_OF_RANGE: assert property ( // RL11
        @(posedge clk_i) disable iff (!nrst_i)
        (classify_valid_i && classify_code_i > CODE_LAST)
            |=> !queue_hit_o && queue_o == QUEUE_DEFAULT)
        else $error("uncovered code claimed a mapped queue");
    AST_WRITE_READBACK: assert property ( // RL12
        @(posedge clk_i) disable iff (!nrst_i)
        (s_write_taken and (word_hit[1] && avs_byteenable_i[1:0] == 2'b11))
            ##1 (!avs_write_i) [*3] ##0 (s_read_taken and word_hit[1])
            |-> avs_readdata_o[15:0] == $past(avs_writedata_i[15:0], 3))
        else $error("read did not return last written value");
    AST_ONE_WAIT: assert property ( // RL12
        @(posedge clk_i) disable iff (!nrst_i)
        ($rose(req) && bus_state_r == BUS_IDLE) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("bus answer not after one wait cycle");

endmodule : dscp_priority_queue_map

// ==== bench/testbench.sv ====
// self-checking bench for the code point queue map bank
`timescale 1ns/1ns
module testbench
    import dscp_map_pkg::*;
;
    // ********
    // signals
    // ********
    logic              clk_i;
    logic              nrst_i;
    logic [ADDR_W-1:0] avs_address_i;
    logic              avs_read_i;
    logic              avs_write_i;
    logic [31:0]       avs_writedata_i;
    logic [3:0]        avs_byteenable_i;
    logic [31:0]       avs_readdata_o;
    logic              avs_waitrequest_o;
    logic              classify_valid_i;
    logic [CODE_W-1:0] classify_code_i;
    logic              queue_valid_o;
    logic [1:0]        queue_o;
    logic              queue_hit_o;
    int                num_errors;
    int                total_checks;
    int                waits;
    logic [15:0]       map_exp [MAP_WORDS];
    logic [31:0]       rd;
    logic [1:0]        eq;
    logic              eh;

    // register rows: address, write data, expected read back
    typedef struct {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
        logic [31:0]       rdata;
    } row_t;
    row_t rows [MAP_WORDS] = '{
        '{10'h1B4, 32'hFFFF_E4E4, 32'h0000_E4E4},
        '{10'h1B8, 32'hABCD_1B1B, 32'h0000_1B1B},
        '{10'h1BC, 32'h0000_C6A5, 32'h0000_C6A5},
        '{10'h1C0, 32'h8000_5A3C, 32'h0000_5A3C}};

    dscp_priority_queue_map i_dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .classify_valid_i(classify_valid_i), .classify_code_i(classify_code_i),
        .queue_valid_o(queue_valid_o), .queue_o(queue_o), .queue_hit_o(queue_hit_o));

    // ********
    // tasks
    // ********
    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t register read %h expected %h", $time, got, exp);
        end
    endtask : check_reg

    task automatic check_q(input logic [3:0] got, input logic [3:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t classify answer %b expected %b", $time, got, exp);
        end
    endtask : check_q

    task automatic check_wait(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t wait cycles %0d expected %0d", $time, got, exp);
        end
    endtask : check_wait

    // one avalon access; held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        waits = 0;
        @(posedge clk_i);
        while (avs_waitrequest_o !== 1'b0) begin
            waits++;
            @(posedge clk_i);
        end
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : bus

    // one-cycle request, answer pulse next cycle, queue and hit then hold
    task automatic classify(input logic [5:0] c, input logic [1:0] q, input logic h);
        @(posedge clk_i);
        classify_valid_i <= 1'b1;
        classify_code_i <= c;
        @(posedge clk_i);
        classify_valid_i <= 1'b0;
        @(negedge clk_i);
        check_q({queue_valid_o, queue_hit_o, queue_o}, {1'b1, h, q});
        @(negedge clk_i);
        check_q({queue_valid_o, queue_hit_o, queue_o}, {1'b0, h, q});
    endtask : classify

    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    // ********
    // clock, reset, stimulus
    // ********
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        #200000;
        num_errors++;
        test_done();
    end

    initial begin
        num_errors = 0;
        total_checks = 0;
        nrst_i = 1'b0;
        avs_address_i = 10'h000;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = 32'h0000_0000;
        avs_byteenable_i = 4'hF;
        classify_valid_i = 1'b0;
        classify_code_i = 6'h00;
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        // reset values and default queue
        for (int i = 0; i < MAP_WORDS; i++) begin
            bus(1'b0, rows[i].addr, 32'h0000_0000, 4'hF, rd);
            check_reg(rd, 32'h0000_0000);
        end
        check_q({queue_valid_o, queue_hit_o, queue_o}, 4'h0);
        classify(6'h27, 2'h0, 1'b1);
        $display("test reset done");
        // rows: write each word and read it straight back, upper half ignored
        for (int i = 0; i < MAP_WORDS; i++) begin
            bus(1'b1, rows[i].addr, rows[i].wdata, 4'hF, rd);
            check_wait(waits, 32'd1);
            map_exp[i] = rows[i].rdata[15:0];
            bus(1'b0, rows[i].addr, 32'h0000_0000, 4'hF, rd);
            check_wait(waits, 32'd1);
            check_reg(rd, rows[i].rdata);
        end
        // every code point, in and out of the bank; fields cover 0 to 3
        for (int c = 0; c < 64; c++) begin
            eh = (c >= 8 && c <= 39);
            eq = eh ? map_exp[(c - 8) / 8][2 * (c % 8) +: 2] : 2'h0;
            classify(c[5:0], eq, eh);
        end
        $display("test map lookup done");
        // low lane only, upper byte kept; new value seen by the next frame
        bus(1'b1, 10'h1C0, 32'h0000_1111, 4'h1, rd);
        bus(1'b0, 10'h1C0, 32'h0000_0000, 4'hF, rd);
        check_reg(rd, 32'h0000_5A11);
        classify(6'h20, 2'h1, 1'b1);
        classify(6'h22, 2'h1, 1'b1);
        $display("test byte lane done");
        // unmapped places: write lost, read zero, map 8-15 at 0x1B4 untouched
        bus(1'b1, 10'h1C4, 32'h0000_FFFF, 4'hF, rd);
        bus(1'b0, 10'h1C4, 32'h0000_0000, 4'hF, rd);
        check_reg(rd, 32'h0000_0000);
        bus(1'b0, 10'h1B0, 32'h0000_0000, 4'hF, rd);
        check_reg(rd, 32'h0000_0000);
        bus(1'b0, 10'h1B4, 32'h0000_0000, 4'hF, rd);
        check_reg(rd, 32'h0000_E4E4);
        $display("test unmapped done");
        // second reset in mid-run clears the map again
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        bus(1'b0, 10'h1C0, 32'h0000_0000, 4'hF, rd);
        check_reg(rd, 32'h0000_0000);
        check_q({queue_valid_o, queue_hit_o, queue_o}, 4'h0);
        classify(6'h0F, 2'h0, 1'b1);
        $display("test second reset done");
        test_done();
    end
endmodule : testbench
